// file: hdl/mlc_pkg.sv
// constants and types for the multi-level limit comparator
package mlc_pkg;
   localparam int          MLC_NUM_LEVELS   = 5;
   localparam int          MLC_DW           = 32;
   localparam int          MLC_AW           = 8;
   // timing
   localparam int          MLC_CLK_PERIOD_NS = 10;
   localparam int          MLC_MS_NS         = 1000000;
   localparam int          MLC_MS_CYCLES     = MLC_MS_NS / MLC_CLK_PERIOD_NS;
   localparam int          MLC_BLINK_MS      = 250;
   // register offsets (byte addresses)
   localparam logic [7:0]  MLC_CTRL_OFS      = 8'h00;
   localparam logic [7:0]  MLC_HYST_W_OFS    = 8'h04;
   localparam logic [7:0]  MLC_HYST_T_OFS    = 8'h08;
   localparam logic [7:0]  MLC_ZBAND_OFS     = 8'h0c;
   localparam logic [7:0]  MLC_STATUS_OFS    = 8'h10;
   localparam logic [7:0]  MLC_ELAPSED_OFS   = 8'h14;
   localparam logic [3:0]  MLC_LVL_BASE_PAGE = 4'h2;
   localparam logic [1:0]  MLC_LVL_UPPER_IDX = 2'h0;
   localparam logic [1:0]  MLC_LVL_LOWER_IDX = 2'h1;
   localparam logic [1:0]  MLC_LVL_START_IDX = 2'h2;
   localparam logic [1:0]  MLC_LVL_END_IDX   = 2'h3;
   // control fields
   localparam int          MLC_CTRL_TIME_BIT = 0;
   localparam int          MLC_CTRL_GATE_BIT = 1;
   localparam int          MLC_CTRL_HYS_LSB  = 2;
   localparam logic [3:0]  MLC_CTRL_RESET    = 4'h0;
   localparam logic [31:0] MLC_WORD_RESET    = 32'h0000_0000;
   // status fields
   localparam int          MLC_ST_LVL_LSB    = 0;
   localparam int          MLC_ST_VLD_BIT    = 3;
   localparam int          MLC_ST_RES_LSB    = 4;
   localparam int          MLC_ST_FAIL_LSB   = 7;
   localparam int          MLC_ST_ZB_BIT     = 9;
   // hysteresis modes
   localparam logic [1:0]  MLC_HYS_UPLO      = 2'h0;
   localparam logic [1:0]  MLC_HYS_UPWARD    = 2'h1;
   localparam logic [1:0]  MLC_HYS_DOWNWARD  = 2'h2;

   typedef enum logic [1:0] {
      MLC_RES_NONE,
      MLC_RES_ABOVE,
      MLC_RES_WITHIN,
      MLC_RES_BELOW
   } mlc_res_e;
endpackage : mlc_pkg

// file: hdl/mlc_limit_comparator.sv
// five-level limit comparator with position/time level switching and hysteresis
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps

module mlc_limit_comparator
   import mlc_pkg::*;
#(
   parameter int MS_CYCLES = mlc_pkg::MLC_MS_CYCLES,
   parameter int BLINK_MS  = mlc_pkg::MLC_BLINK_MS
) (
   // clock and reset
   input  wire logic                              clk_i,
   input  wire logic                              rst_n_i,
   // register port
   input  wire logic [mlc_pkg::MLC_AW-1:0]        reg_addr_i,
   input  wire logic [mlc_pkg::MLC_DW-1:0]        reg_wdata_i,
   input  wire logic                              reg_wr_i,
   input  wire logic                              reg_rd_i,
   output logic      [mlc_pkg::MLC_DW-1:0]        reg_rdata_o,
   // measurement and contacts
   input  wire logic                              sample_valid_i,
   input  wire logic signed [mlc_pkg::MLC_DW-1:0] sample_value_i,
   input  wire logic                              gate_i,
   input  wire logic [mlc_pkg::MLC_NUM_LEVELS-1:0] level_position_inputs_i,
   // result outputs
   output logic                                   above_upper_result_o,
   output logic                                   within_result_o,
   output logic                                   below_lower_result_o,
   output logic                                   fail_indicator_red_o,
   output logic                                   fail_indicator_orange_o,
   // level indicators
   output logic      [mlc_pkg::MLC_NUM_LEVELS-1:0] lvl_red_o,
   output logic      [mlc_pkg::MLC_NUM_LEVELS-1:0] lvl_green_o,
   output logic      [mlc_pkg::MLC_NUM_LEVELS-1:0] lvl_orange_o
);
   import mlc_pkg::*;

   localparam int NL = MLC_NUM_LEVELS;

   ////////////////////////////////////////////////////////////////////////////
   // reset release
   logic                   rst_q1_reg;
   logic                   rst_n;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_q1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_q1_reg <= 1'b1;
         rst_n      <= rst_q1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // settings
   logic [3:0]             ctrl_reg;
   logic [MLC_DW-1:0]      hyst_w_reg;
   logic [MLC_DW-1:0]      hyst_t_reg;
   logic [MLC_DW-1:0]      zband_reg;
   logic signed [MLC_DW-1:0] upper_reg [NL];
   logic signed [MLC_DW-1:0] lower_reg [NL];
   logic signed [MLC_DW-1:0] start_reg [NL];
   logic signed [MLC_DW-1:0] end_reg   [NL];
   logic [3:0]             lvl_page;
   logic [2:0]             lvl_sel;
   logic                   lvl_hit;
   logic                   time_mode;
   logic                   gate_use;
   logic [1:0]             hys_mode;

   assign time_mode = ctrl_reg[MLC_CTRL_TIME_BIT];
   assign gate_use  = ctrl_reg[MLC_CTRL_GATE_BIT];
   assign hys_mode  = ctrl_reg[MLC_CTRL_HYS_LSB +: 2];
   assign lvl_page  = reg_addr_i[7:4] - MLC_LVL_BASE_PAGE;
   assign lvl_sel   = lvl_page[2:0];
   assign lvl_hit   = (reg_addr_i[7:4] >= MLC_LVL_BASE_PAGE) && (lvl_page < 4'(NL)) && (reg_addr_i[1:0] == 2'h0);

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg   <= MLC_CTRL_RESET;
         hyst_w_reg <= MLC_WORD_RESET;
         hyst_t_reg <= MLC_WORD_RESET;
         zband_reg  <= MLC_WORD_RESET;
         for (int i = 0; i < NL; i++) begin
            upper_reg[i] <= MLC_WORD_RESET;
            lower_reg[i] <= MLC_WORD_RESET;
            start_reg[i] <= MLC_WORD_RESET;
            end_reg[i]   <= MLC_WORD_RESET;
         end
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            MLC_CTRL_OFS:   ctrl_reg   <= reg_wdata_i[3:0];
            MLC_HYST_W_OFS: hyst_w_reg <= reg_wdata_i;
            MLC_HYST_T_OFS: hyst_t_reg <= reg_wdata_i;
            MLC_ZBAND_OFS:  zband_reg  <= reg_wdata_i;
            default: begin
               if (lvl_hit) begin
                  case (reg_addr_i[3:2])
                     MLC_LVL_UPPER_IDX: upper_reg[lvl_sel] <= reg_wdata_i;
                     MLC_LVL_LOWER_IDX: lower_reg[lvl_sel] <= reg_wdata_i;
                     MLC_LVL_START_IDX: start_reg[lvl_sel] <= reg_wdata_i;
                     default:           end_reg[lvl_sel]   <= reg_wdata_i;
                  endcase
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // gate, millisecond tick, elapsed time
   logic                   gate_eff;
   logic                   gate_q_reg;
   logic                   gate_rise;
   logic [31:0]            tick_cnt_reg;
   logic                   ms_tick;
   logic [MLC_DW-1:0]      elapsed_reg;

   // gate only counts when its use is enabled
   assign gate_eff  = gate_use ? gate_i : 1'b1;
   assign gate_rise = gate_eff && !gate_q_reg;
   assign ms_tick   = (tick_cnt_reg == 32'(MS_CYCLES - 1));

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         gate_q_reg   <= 1'b0;
         tick_cnt_reg <= 32'h0;
      end else begin
         gate_q_reg   <= gate_eff;
         tick_cnt_reg <= ms_tick ? 32'h0 : tick_cnt_reg + 32'h1;
      end
   end

   // elapsed time restarts at gate assertion
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         elapsed_reg <= MLC_WORD_RESET;
      end else if (gate_rise) begin
         elapsed_reg <= MLC_WORD_RESET;
      end else if (gate_eff && ms_tick && (elapsed_reg != 32'h7fff_ffff)) begin
         elapsed_reg <= elapsed_reg + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // active level selection, lowest numbered level wins on overlap
   logic [NL-1:0]          lvl_on;
   logic                   act_vld;
   logic [2:0]             act_idx;

   for (genvar g = 0; g < NL; g++) begin : g_sel
      // position or time window, negative time skips
      assign lvl_on[g] = time_mode ?
                         (!start_reg[g][MLC_DW-1] && !end_reg[g][MLC_DW-1] &&
                          ($signed(elapsed_reg) >= start_reg[g]) && ($signed(elapsed_reg) < end_reg[g])) :
                         level_position_inputs_i[g];
   end

   always_comb begin
      act_vld = 1'b0;
      act_idx = 3'h0;
      for (int i = NL - 1; i >= 0; i--) begin
         if (lvl_on[i]) begin
            act_vld = 1'b1;
            act_idx = 3'(i);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // judgment with hysteresis
   mlc_res_e               res_reg [NL];
   mlc_res_e               cur;
   mlc_res_e               res_next;
   logic signed [MLC_DW+1:0] v_x;
   logic signed [MLC_DW+1:0] up_x;
   logic signed [MLC_DW+1:0] lo_x;
   logic signed [MLC_DW+1:0] hw_x;
   logic signed [MLC_DW+1:0] zb_x;
   logic                   over;
   logic                   under;
   logic                   in_zband;
   logic                   pend;
   logic                   pend_reg;
   logic                   tmr_done;
   logic [MLC_DW-1:0]      hyst_cnt_reg;
   logic                   prev_vld_reg;
   logic [2:0]             prev_idx_reg;
   logic                   lvl_moved;
   logic                   judge;
   logic                   zb_reg;

   assign v_x      = (MLC_DW+2)'(sample_value_i);
   assign up_x     = (MLC_DW+2)'(upper_reg[act_idx]);
   assign lo_x     = (MLC_DW+2)'(lower_reg[act_idx]);
   assign hw_x     = $signed({2'b00, hyst_w_reg});
   assign zb_x     = $signed({2'b00, zband_reg});
   assign over     = v_x > up_x;
   assign under    = v_x < lo_x;
   assign in_zband = (v_x <= zb_x) && (v_x >= -zb_x);
   // a zero hysteresis time means only the width releases the result
   assign tmr_done = (hyst_t_reg != 32'h0) && (hyst_cnt_reg >= hyst_t_reg);
   assign lvl_moved = (act_vld != prev_vld_reg) || (act_idx != prev_idx_reg);
   // judge only with gate on and a level active
   assign judge    = sample_valid_i && gate_eff && act_vld && !in_zband;

   always_comb begin
      cur      = (res_reg[act_idx] == MLC_RES_NONE) ? MLC_RES_WITHIN : res_reg[act_idx];
      res_next = cur;
      pend     = 1'b0;
      case (cur)
         MLC_RES_ABOVE: begin
            if (under) begin
               res_next = (hys_mode == MLC_HYS_UPWARD) ? MLC_RES_WITHIN : MLC_RES_BELOW;
            end else if (!over) begin
               if (hys_mode == MLC_HYS_DOWNWARD) begin
                  res_next = MLC_RES_WITHIN;
               end else if ((v_x <= up_x - hw_x) || tmr_done) begin
                  res_next = MLC_RES_WITHIN;
               end else begin
                  pend = 1'b1;
               end
            end
         end
         MLC_RES_BELOW: begin
            if (over) begin
               res_next = (hys_mode == MLC_HYS_DOWNWARD) ? MLC_RES_WITHIN : MLC_RES_ABOVE;
            end else if (!under) begin
               if (hys_mode == MLC_HYS_UPWARD) begin
                  res_next = MLC_RES_WITHIN;
               end else if ((v_x >= lo_x + hw_x) || tmr_done) begin
                  res_next = MLC_RES_WITHIN;
               end else begin
                  pend = 1'b1;
               end
            end
         end
         default: begin
            if (over) begin
               // downward above needs width or time
               if ((hys_mode != MLC_HYS_DOWNWARD) || (v_x > up_x + hw_x) || tmr_done) begin
                  res_next = MLC_RES_ABOVE;
               end else begin
                  pend = 1'b1;
               end
            end else if (under) begin
               // upward below needs width or time
               if ((hys_mode != MLC_HYS_UPWARD) || (v_x < lo_x - hw_x) || tmr_done) begin
                  res_next = MLC_RES_BELOW;
               end else begin
                  pend = 1'b1;
               end
            end
         end
      endcase
   end

   // per-level results, cleared at the start of each gated cycle
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NL; i++) begin
            res_reg[i] <= MLC_RES_NONE;
         end
      end else if (gate_rise) begin
         for (int i = 0; i < NL; i++) begin
            res_reg[i] <= MLC_RES_NONE;
         end
      end else if (judge) begin
         res_reg[act_idx] <= res_next;
      end
   end

   // hysteresis timer runs from re-crossing, cancelled on crossing back
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pend_reg     <= 1'b0;
         hyst_cnt_reg <= MLC_WORD_RESET;
         prev_vld_reg <= 1'b0;
         prev_idx_reg <= 3'h0;
      end else begin
         prev_vld_reg <= act_vld;
         prev_idx_reg <= act_idx;
         if (lvl_moved || gate_rise || !gate_eff) begin
            pend_reg     <= 1'b0;
            hyst_cnt_reg <= MLC_WORD_RESET;
         end else begin
            if (judge) begin
               pend_reg <= pend;
            end
            // keeps counting between samples as well, else a held value never releases
            if (judge && !pend) begin
               hyst_cnt_reg <= MLC_WORD_RESET;
            end else if ((judge ? pend : pend_reg) && ms_tick && (hyst_cnt_reg != 32'hffff_ffff)) begin
               hyst_cnt_reg <= hyst_cnt_reg + 32'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   logic [MLC_DW-1:0]      blink_cnt_reg;
   logic                   blink_reg;
   logic [NL-1:0]          any_above;
   logic [NL-1:0]          any_below;
   mlc_res_e               act_res;

   assign act_res = res_reg[act_idx];

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         blink_cnt_reg <= MLC_WORD_RESET;
         blink_reg     <= 1'b0;
      end else if (ms_tick) begin
         if (blink_cnt_reg >= 32'(BLINK_MS - 1)) begin
            blink_cnt_reg <= MLC_WORD_RESET;
            blink_reg     <= !blink_reg;
         end else begin
            blink_cnt_reg <= blink_cnt_reg + 32'h1;
         end
      end
   end

   // colour per level, active one blinks while gate on
   for (genvar g = 0; g < NL; g++) begin : g_ind
      assign any_above[g] = (res_reg[g] == MLC_RES_ABOVE);
      assign any_below[g] = (res_reg[g] == MLC_RES_BELOW);
      always_ff @(posedge clk_i or negedge rst_n) begin
         if (!rst_n) begin
            lvl_red_o[g]    <= 1'b0;
            lvl_green_o[g]  <= 1'b0;
            lvl_orange_o[g] <= 1'b0;
         end else begin
            if (gate_eff && act_vld && (act_idx == 3'(g)) && !blink_reg) begin
               lvl_red_o[g]    <= 1'b0;
               lvl_green_o[g]  <= 1'b0;
               lvl_orange_o[g] <= 1'b0;
            end else begin
               lvl_red_o[g]    <= any_above[g];
               lvl_green_o[g]  <= (res_reg[g] == MLC_RES_WITHIN);
               lvl_orange_o[g] <= any_below[g];
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         zb_reg                  <= 1'b0;
         above_upper_result_o    <= 1'b0;
         within_result_o         <= 1'b0;
         below_lower_result_o    <= 1'b0;
         fail_indicator_red_o    <= 1'b0;
         fail_indicator_orange_o <= 1'b0;
      end else begin
         if (sample_valid_i) begin
            zb_reg <= in_zband;
         end
         // result outputs withheld when gate off or in zero band
         // results clear at gate rise, so stale ones must not reach the pins on that edge
         if (!gate_eff || gate_rise || !act_vld || zb_reg) begin
            above_upper_result_o <= 1'b0;
            within_result_o      <= 1'b0;
            below_lower_result_o <= 1'b0;
         end else begin
            above_upper_result_o <= (act_res == MLC_RES_ABOVE);
            within_result_o      <= (act_res == MLC_RES_WITHIN);
            below_lower_result_o <= (act_res == MLC_RES_BELOW);
         end
         fail_indicator_red_o    <= |any_above;
         fail_indicator_orange_o <= !(|any_above) && (|any_below);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read, data valid the cycle after the strobe
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o <= MLC_WORD_RESET;
      end else if (reg_rd_i) begin
         reg_rdata_o <= MLC_WORD_RESET;
         case (reg_addr_i)
            MLC_CTRL_OFS:    reg_rdata_o <= {28'h0, ctrl_reg};
            MLC_HYST_W_OFS:  reg_rdata_o <= hyst_w_reg;
            MLC_HYST_T_OFS:  reg_rdata_o <= hyst_t_reg;
            MLC_ZBAND_OFS:   reg_rdata_o <= zband_reg;
            MLC_ELAPSED_OFS: reg_rdata_o <= elapsed_reg;
            MLC_STATUS_OFS: begin
               reg_rdata_o[MLC_ST_LVL_LSB +: 3] <= act_idx;
               reg_rdata_o[MLC_ST_VLD_BIT]      <= act_vld;
               reg_rdata_o[MLC_ST_RES_LSB +: 3] <= {below_lower_result_o, within_result_o, above_upper_result_o};
               reg_rdata_o[MLC_ST_FAIL_LSB +: 2] <= {fail_indicator_orange_o, fail_indicator_red_o};
               reg_rdata_o[MLC_ST_ZB_BIT]       <= zb_reg;
            end
            default: begin
               if (lvl_hit) begin
                  case (reg_addr_i[3:2])
                     MLC_LVL_UPPER_IDX: reg_rdata_o <= upper_reg[lvl_sel];
                     MLC_LVL_LOWER_IDX: reg_rdata_o <= lower_reg[lvl_sel];
                     MLC_LVL_START_IDX: reg_rdata_o <= start_reg[lvl_sel];
                     default:           reg_rdata_o <= end_reg[lvl_sel];
                  endcase
               end
            end
         endcase
      end else begin
         reg_rdata_o <= MLC_WORD_RESET;
      end
   end

endmodule // mlc_limit_comparator

// file: verif/mlc_contact_model.sv
// position switch and gate contact model for the limit comparator
`timescale 1ns/1ps
module mlc_contact_model
   import mlc_pkg::*;
(
   // clock and command
   input  wire logic                 clk_i,
   input  wire logic [2:0]           level_sel_i,
   input  wire logic                 gate_req_i,
   // contacts
   output logic [MLC_NUM_LEVELS-1:0] level_position_inputs_o = '0,
   output logic                      gate_o = 1'b0
);
   // at most one switch closed, none for a select of zero
   // contacts move one edge after the command, like a slow mechanical switch
   always @(posedge clk_i) begin
      level_position_inputs_o <= (level_sel_i == 3'h0) ? '0 : 5'(5'h01 << (level_sel_i - 3'h1));
      gate_o <= gate_req_i;
   end
endmodule // mlc_contact_model

// file: verif/mlc_limit_comparator_monitor.sv
// assertions on the limit comparator ports
`timescale 1ns/1ps
module mlc_limit_comparator_monitor
   import mlc_pkg::*;
(
   input wire logic                      clk_i,
   input wire logic                      rst_n_i,
   input wire logic [MLC_AW-1:0]         reg_addr_i,
   input wire logic [MLC_DW-1:0]         reg_wdata_i,
   input wire logic                      reg_wr_i,
   input wire logic                      sample_valid_i,
   input wire logic signed [MLC_DW-1:0]  sample_value_i,
   input wire logic                      gate_i,
   input wire logic [MLC_NUM_LEVELS-1:0] level_position_inputs_i,
   input wire logic                      above_upper_result_o,
   input wire logic                      within_result_o,
   input wire logic                      below_lower_result_o,
   input wire logic                      fail_indicator_red_o,
   input wire logic                      fail_indicator_orange_o,
   input wire logic [MLC_NUM_LEVELS-1:0] lvl_red_o,
   input wire logic [MLC_NUM_LEVELS-1:0] lvl_green_o,
   input wire logic [MLC_NUM_LEVELS-1:0] lvl_orange_o
);
   logic [1:0]              ctrl_reg;
   logic signed [MLC_DW-1:0] zb_reg;
   logic [2:0]              res;
   logic                    in_band;
   assign res = {above_upper_result_o, within_result_o, below_lower_result_o};
   assign in_band = (sample_value_i <= zb_reg) && (sample_value_i >= -zb_reg);
   // shadow of mode and zero band, since the checker cannot see the registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_reg <= 2'h0;
         zb_reg <= '0;
      end else if (reg_wr_i) begin
         if (reg_addr_i == MLC_CTRL_OFS) ctrl_reg <= reg_wdata_i[1:0];
         if (reg_addr_i == MLC_ZBAND_OFS) zb_reg <= reg_wdata_i;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   chk_result_exclusive: assert property ($onehot0(res))
      else $error("more than one result output high");
   chk_colour_exclusive: assert property (((lvl_red_o & lvl_green_o) | (lvl_orange_o & (lvl_red_o | lvl_green_o))) == '0)
      else $error("level indicator shows two colours");
   chk_above_fail_red: assert property (above_upper_result_o |-> fail_indicator_red_o)
      else $error("above result without red fail");
   chk_below_fail_lit: assert property (below_lower_result_o |-> fail_indicator_red_o || fail_indicator_orange_o)
      else $error("below result with fail dark");
   chk_fail_one_colour: assert property (!(fail_indicator_red_o && fail_indicator_orange_o))
      else $error("fail indicator red and orange at once");
   chk_gate_off_quiet: assert property (ctrl_reg[1] && !gate_i && !$past(gate_i) |-> ##2 res == 3'h0)
      else $error("result output while gate off");
   chk_zero_band_quiet: assert property (sample_valid_i && (!ctrl_reg[1] || gate_i) && in_band |-> ##2 res == 3'h0)
      else $error("result output for value in zero band");
   chk_no_level_quiet: assert property (!ctrl_reg[0] && level_position_inputs_i == '0 && $stable(level_position_inputs_i)
      |-> ##2 res == 3'h0)
      else $error("result output with no position contact");
endmodule // mlc_limit_comparator_monitor

bind mlc_limit_comparator mlc_limit_comparator_monitor i_mlc_limit_comparator_monitor (.clk_i, .rst_n_i, .reg_addr_i,
   .reg_wdata_i, .reg_wr_i, .sample_valid_i, .sample_value_i, .gate_i, .level_position_inputs_i, .above_upper_result_o,
   .within_result_o, .below_lower_result_o, .fail_indicator_red_o, .fail_indicator_orange_o, .lvl_red_o, .lvl_green_o,
   .lvl_orange_o);

// file: verif/testbench.sv
// self-checking bench for the limit comparator
`timescale 1ns/1ps
module testbench;
   import mlc_pkg::*;
   localparam logic [2:0] AB = 3'h4, WI = 3'h2, BE = 3'h1, NO = 3'h0;
   logic clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, sample_valid_i = 1'b0, gate_req = 1'b0;
   logic [7:0] reg_addr_i = '0;
   logic [31:0] reg_wdata_i = '0, reg_rdata_o;
   logic signed [31:0] sample_value_i = '0;
   logic [2:0] level_sel = 3'h1;
   logic gate_i, above_upper_result_o, within_result_o, below_lower_result_o;
   logic fail_indicator_red_o, fail_indicator_orange_o;
   logic [4:0] level_position_inputs_i, lvl_red_o, lvl_green_o, lvl_orange_o;
   int fails = 0, checks_done = 0, cycles = 0;
   always #5 clk_i = ~clk_i;
   mlc_contact_model i_mlc_contact_model (.clk_i, .level_sel_i(level_sel), .gate_req_i(gate_req),
      .level_position_inputs_o(level_position_inputs_i), .gate_o(gate_i));
   // short millisecond and blink counts keep the run brief
   mlc_limit_comparator #(.MS_CYCLES(10), .BLINK_MS(2)) i_mlc_limit_comparator (.clk_i, .rst_n_i, .reg_addr_i,
      .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sample_valid_i, .sample_value_i, .gate_i,
      .level_position_inputs_i, .above_upper_result_o, .within_result_o, .below_lower_result_o,
      .fail_indicator_red_o, .fail_indicator_orange_o, .lvl_red_o, .lvl_green_o, .lvl_orange_o);
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 check("read data", exp, reg_rdata_o);
   endtask
   task automatic lvl(input int n, input int up, input int lo, input int st, input int en);
      wr(8'h20 + 8'(n * 16), up);
      wr(8'h24 + 8'(n * 16), lo);
      wr(8'h28 + 8'(n * 16), st);
      wr(8'h2c + 8'(n * 16), en);
   endtask
   task automatic res(input logic [2:0] e);
      check("result outputs", 32'(e), 32'({above_upper_result_o, within_result_o, below_lower_result_o}));
   endtask
   // outputs follow two edges after the sample is taken
   task automatic smp(input int v, input logic [2:0] e);
      @(posedge clk_i);
      sample_valid_i <= 1'b1;
      sample_value_i <= v;
      @(posedge clk_i);
      sample_valid_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1 res(e);
   endtask
   task automatic done(input string t);
      $display("test %s done", t);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails = fails + 1;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(MLC_CTRL_OFS, 32'h0);
      lvl(0, 100, -100, 2, 4);
      lvl(1, 500, 300, -1, 10);
      wr(MLC_HYST_W_OFS, 32'd10);
      rd(8'h2c, 32'd4);
      rd(8'h38, 32'hffff_ffff);
      rd(8'hf0, 32'h0);
      done("registers");
      smp(200, AB);
      check("fail red", 32'h1, 32'(fail_indicator_red_o));
      smp(95, AB);
      smp(50, WI);
      smp(-150, BE);
      smp(-95, BE);
      check("fail orange", 32'h1, 32'(fail_indicator_orange_o));
      level_sel <= 3'h2;
      repeat (4) @(posedge clk_i);
      smp(600, AB);
      check("level one steady", 32'h1, 32'(lvl_orange_o[0]));
      check("fail mixed", 32'h1, 32'(fail_indicator_red_o));
      done("upper lower");
      level_sel <= 3'h1;
      wr(MLC_CTRL_OFS, 32'h4);
      repeat (4) @(posedge clk_i);
      smp(50, WI);
      smp(200, AB);
      smp(95, AB);
      smp(-105, WI);
      smp(-150, BE);
      smp(-50, WI);
      wr(MLC_CTRL_OFS, 32'h8);
      smp(105, WI);
      smp(150, AB);
      smp(95, WI);
      smp(-150, BE);
      smp(-95, BE);
      smp(-50, WI);
      done("directional");
      wr(MLC_CTRL_OFS, 32'h0);
      wr(MLC_HYST_T_OFS, 32'd2);
      smp(200, AB);
      sample_value_i <= 95;
      sample_valid_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      #1 res(AB);
      repeat (30) @(posedge clk_i);
      #1 res(WI);
      sample_valid_i <= 1'b0;
      wr(MLC_HYST_T_OFS, 32'd0);
      done("hysteresis time");
      wr(MLC_CTRL_OFS, 32'h2);
      repeat (4) @(posedge clk_i);
      smp(200, NO);
      check("level one green", 32'h1, 32'(lvl_green_o[0]));
      gate_req <= 1'b1;
      repeat (4) @(posedge clk_i);
      smp(200, AB);
      wr(MLC_ZBAND_OFS, 32'd60);
      smp(-60, NO);
      wr(MLC_ZBAND_OFS, 32'd0);
      done("gate and zero band");
      gate_req <= 1'b0;
      wr(MLC_CTRL_OFS, 32'h3);
      repeat (4) @(posedge clk_i);
      gate_req <= 1'b1;
      sample_value_i <= 200;
      sample_valid_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      #1 res(NO);
      repeat (20) @(posedge clk_i);
      #1 res(AB);
      repeat (20) @(posedge clk_i);
      #1 res(NO);
      check("level one red", 32'h1, 32'(lvl_red_o[0]));
      sample_valid_i <= 1'b0;
      done("time control");
      conclude();
   end
endmodule // testbench
